/* File: include/uicfc_pkg.sv */
// Constants and carrier types for the interrupt id / fifo control block.
// Assumes the register port of the host interface front end, on CLOCK.
package uicfc_pkg;

	// ************
	// Offsets
	// ************
	localparam logic [7:0] OFS_BAUD_DIVISOR_HIGH   = 8'h01;
	localparam logic [7:0] OFS_INTERRUPT_SOURCE_ID = 8'h02;
	localparam logic [7:0] OFS_FIFO_CONTROL        = 8'h02;
	localparam logic [7:0] LINE_CONTROL_ENHANCED   = 8'hbf;

	// ************
	// Reset values
	// ************
	localparam logic [7:0] RST_BAUD_DIVISOR_HIGH   = 8'h00;
	localparam logic [7:0] RST_FIFO_CONTROL        = 8'h00;
	localparam logic [7:0] RST_INTERRUPT_SOURCE_ID = 8'h01;

	// ************
	// Field positions
	// ************
	localparam int BANK_SELECT_BIT   = 7;
	localparam int ENHANCED_EN_BIT   = 4;
	localparam int FC_ENABLE_BIT     = 0;
	localparam int FC_RX_RESET_BIT   = 1;
	localparam int FC_TX_RESET_BIT   = 2;
	localparam int FC_TX_TRIG_LSB    = 4;
	localparam int FC_RX_TRIG_LSB    = 6;

	// ************
	// Identification codes, bits 5:0
	// ************
	localparam logic [5:0] ID_NONE       = 6'h01;
	localparam logic [5:0] ID_LINE_ERROR = 6'h06;
	localparam logic [5:0] ID_RX_TIMEOUT = 6'h0c;
	localparam logic [5:0] ID_RX_DATA    = 6'h04;
	localparam logic [5:0] ID_TX_READY   = 6'h02;
	localparam logic [5:0] ID_MODEM      = 6'h00;
	localparam logic [5:0] ID_PIN_CHANGE = 6'h30;
	localparam logic [5:0] ID_XOFF_SPEC  = 6'h10;
	localparam logic [5:0] ID_FLOW_DROP  = 6'h20;

	// ************
	// Trigger levels
	// ************
	localparam logic [6:0] RX_TRIG_00 = 7'h08;
	localparam logic [6:0] RX_TRIG_01 = 7'h10;
	localparam logic [6:0] RX_TRIG_10 = 7'h38;
	localparam logic [6:0] RX_TRIG_11 = 7'h3c;
	localparam logic [6:0] TX_TRIG_00 = 7'h08;
	localparam logic [6:0] TX_TRIG_01 = 7'h10;
	localparam logic [6:0] TX_TRIG_10 = 7'h20;
	localparam logic [6:0] TX_TRIG_11 = 7'h38;
	localparam logic [6:0] TRIG_SINGLE = 7'h01;

	// Register access from the host interface front end
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} uicfc_access_t;

	// Enabled, pending interrupt sources
	typedef struct packed {
		logic line_error;
		logic rx_timeout;
		logic rx_data;
		logic tx_ready;
		logic modem;
		logic pin_change;
		logic xoff;
		logic special_char;
		logic xon;
		logic flow_drop;
	} uicfc_sources_t;

endpackage

/* File: src/uicfc_regs.sv */
// Divisor high byte, interrupt identification and fifo control registers.
// Assumes a register front end on CLOCK and source flags already enabled.
`timescale 1ns/10ps
module uicfc_regs
	import uicfc_pkg::*;
(
	input  wire logic                     CLOCK,
	input  wire logic                     RSTN,
	input  wire logic                     SOFT_RESET,
	input  wire uicfc_pkg::uicfc_access_t ACCESS,
	input  wire logic [7:0]               LINE_CONTROL,
	input  wire logic [7:0]               ENHANCED_FEATURE,
	input  wire uicfc_pkg::uicfc_sources_t SOURCES,
	output logic [7:0]                    RDATA,
	output logic                          RDATA_VALID,
	output logic [7:0]                    BAUD_DIVISOR_HIGH,
	output logic                          FIFO_ENABLE,
	output logic [6:0]                    RX_TRIGGER,
	output logic [6:0]                    TX_TRIGGER,
	output logic                          TX_FIFO_FLUSH,
	output logic                          RX_FIFO_FLUSH
);
	import uicfc_pkg::*;

	// ************
	// Decode
	// ************
	function automatic logic [6:0] rx_level(input logic [1:0] code);
		unique case (code)
			2'b00: rx_level = RX_TRIG_00;
			2'b01: rx_level = RX_TRIG_01;
			2'b10: rx_level = RX_TRIG_10;
			2'b11: rx_level = RX_TRIG_11;
		endcase
	endfunction

	function automatic logic [6:0] tx_level(input logic [1:0] code);
		unique case (code)
			2'b00: tx_level = TX_TRIG_00;
			2'b01: tx_level = TX_TRIG_01;
			2'b10: tx_level = TX_TRIG_10;
			2'b11: tx_level = TX_TRIG_11;
		endcase
	endfunction

	logic       divisor_bank;
	logic       normal_bank;
	logic       enhanced_en;
	logic [7:0] divisor_high;
	logic [7:0] next_divisor_high;
	logic [7:0] fifo_control;
	logic [7:0] next_fifo_control;
	logic       xoff_flag;
	logic       next_xoff_flag;
	logic       special_flag;
	logic       next_special_flag;
	logic [5:0] id_code;
	logic [7:0] id_value;
	logic       id_read;
	logic [7:0] next_rdata;
	logic       next_rdata_valid;
	logic [6:0] next_rx_trigger;
	logic [6:0] next_tx_trigger;
	logic       next_tx_flush;
	logic       next_rx_flush;

	assign divisor_bank = LINE_CONTROL[BANK_SELECT_BIT] && (LINE_CONTROL != LINE_CONTROL_ENHANCED);
	assign normal_bank  = !LINE_CONTROL[BANK_SELECT_BIT];
	assign enhanced_en  = ENHANCED_FEATURE[ENHANCED_EN_BIT];
	assign id_read      = ACCESS.rd && normal_bank && (ACCESS.addr == OFS_INTERRUPT_SOURCE_ID);

	// ************
	// Identification encoding
	// ************
	always_comb
	begin
		if (SOURCES.line_error)
			id_code = ID_LINE_ERROR;
		else if (SOURCES.rx_timeout)
			id_code = ID_RX_TIMEOUT;
		else if (SOURCES.rx_data)
			id_code = ID_RX_DATA;
		else if (SOURCES.tx_ready)
			id_code = ID_TX_READY;
		else if (SOURCES.modem)
			id_code = ID_MODEM;
		else if (SOURCES.pin_change)
			id_code = ID_PIN_CHANGE;
		else if (xoff_flag || special_flag)
			id_code = ID_XOFF_SPEC;
		else if (SOURCES.flow_drop)
			id_code = ID_FLOW_DROP;
		else
			id_code = ID_NONE;
		id_value = {{2{fifo_control[FC_ENABLE_BIT]}}, id_code};
	end

	// ************
	// Next state
	// ************
	always_comb
	begin
		next_divisor_high = divisor_high;
		next_fifo_control = fifo_control;
		next_tx_flush     = 1'b0;
		next_rx_flush     = 1'b0;
		// Soft reset is looked at last, below; it deliberately leaves the divisor alone
		if (ACCESS.wr && divisor_bank && ACCESS.addr == OFS_BAUD_DIVISOR_HIGH)
			next_divisor_high = ACCESS.wdata;
		if (ACCESS.wr && normal_bank && ACCESS.addr == OFS_FIFO_CONTROL)
		begin
			next_fifo_control[FC_ENABLE_BIT] = ACCESS.wdata[FC_ENABLE_BIT];
			if (ACCESS.wdata[FC_ENABLE_BIT])
			begin
				next_fifo_control[7:6] = ACCESS.wdata[7:6];
				if (enhanced_en)
					next_fifo_control[5:4] = ACCESS.wdata[5:4];
				next_tx_flush = ACCESS.wdata[FC_TX_RESET_BIT];
				next_rx_flush = ACCESS.wdata[FC_RX_RESET_BIT];
			end
		end
		// Flush bits never stored, so they read back as cleared
		next_fifo_control[3:1] = 3'b000;
		if (fifo_control[FC_ENABLE_BIT])
		begin
			next_rx_trigger = rx_level(fifo_control[FC_RX_TRIG_LSB +: 2]);
			next_tx_trigger = tx_level(fifo_control[FC_TX_TRIG_LSB +: 2]);
		end
		else
		begin
			next_rx_trigger = TRIG_SINGLE;
			next_tx_trigger = TRIG_SINGLE;
		end
		// Set wins over clear on both flags
		next_xoff_flag    = SOURCES.xoff || (xoff_flag && !SOURCES.xon);
		next_special_flag = SOURCES.special_char || (special_flag && !id_read);
		if (SOFT_RESET)
		begin
			next_fifo_control = RST_FIFO_CONTROL;
			next_xoff_flag    = 1'b0;
			next_special_flag = 1'b0;
		end
	end

	// ************
	// Registers
	// ************
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			divisor_high  <= RST_BAUD_DIVISOR_HIGH;
			fifo_control  <= RST_FIFO_CONTROL;
			xoff_flag     <= 1'b0;
			special_flag  <= 1'b0;
			TX_FIFO_FLUSH <= 1'b0;
			RX_FIFO_FLUSH <= 1'b0;
			RX_TRIGGER    <= TRIG_SINGLE;
			TX_TRIGGER    <= TRIG_SINGLE;
		end
		else
		begin
			divisor_high  <= next_divisor_high;
			fifo_control  <= next_fifo_control;
			xoff_flag     <= next_xoff_flag;
			special_flag  <= next_special_flag;
			TX_FIFO_FLUSH <= next_tx_flush;
			RX_FIFO_FLUSH <= next_rx_flush;
			RX_TRIGGER    <= next_rx_trigger;
			TX_TRIGGER    <= next_tx_trigger;
		end
	end

	// ************
	// Read path
	// ************
	// Own group: read data is a one-cycle answer, the rest is held state
	always_comb
	begin
		next_rdata       = 8'h00;
		next_rdata_valid = ACCESS.rd;
		if (ACCESS.rd)
		begin
			if (divisor_bank && ACCESS.addr == OFS_BAUD_DIVISOR_HIGH)
				next_rdata = divisor_high;
			else if (id_read)
				next_rdata = id_value;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			RDATA       <= 8'h00;
			RDATA_VALID <= 1'b0;
		end
		else
		begin
			RDATA       <= next_rdata;
			RDATA_VALID <= next_rdata_valid;
		end
	end

	assign BAUD_DIVISOR_HIGH = divisor_high;
	assign FIFO_ENABLE       = fifo_control[FC_ENABLE_BIT];

endmodule

/* File: dv/uicfc_regs_asserts.sv */
// Port checker for uicfc_regs.
// Assumes one clock domain, bound to every uicfc_regs instance.
`timescale 1ns/10ps
module uicfc_regs_asserts
	import uicfc_pkg::*;
(
	input wire logic                      CLOCK,
	input wire logic                      RSTN,
	input wire uicfc_pkg::uicfc_access_t  ACCESS,
	input wire logic [7:0]                LINE_CONTROL,
	input wire uicfc_pkg::uicfc_sources_t SOURCES,
	input wire logic [7:0]                RDATA,
	input wire logic [7:0]                BAUD_DIVISOR_HIGH,
	input wire logic                      FIFO_ENABLE,
	input wire logic [6:0]                RX_TRIGGER,
	input wire logic [6:0]                TX_TRIGGER,
	input wire logic                      TX_FIFO_FLUSH,
	input wire logic                      RX_FIFO_FLUSH
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	wire fc_wr = ACCESS.wr && ACCESS.addr == 8'h02 && !LINE_CONTROL[7];
	wire id_rd = ACCESS.rd && ACCESS.addr == 8'h02 && !LINE_CONTROL[7];
	wire dl_wr = ACCESS.wr && ACCESS.addr == 8'h01 && LINE_CONTROL[7] && LINE_CONTROL != 8'hbf;
	sequence s_fc_en;
		fc_wr && ACCESS.wdata[0];
	endsequence
	property p_dl_wr; dl_wr |=> BAUD_DIVISOR_HIGH == $past(ACCESS.wdata); endproperty
	a_dl_wr: assert property (p_dl_wr) else $error("divisor write lost");
	property p_dl_hold; !dl_wr |=> $stable(BAUD_DIVISOR_HIGH); endproperty
	a_dl_hold: assert property (p_dl_hold) else $error("divisor changed");
	property p_mirror; id_rd |=> RDATA[7:6] == {2{$past(FIFO_ENABLE)}}; endproperty
	a_mirror: assert property (p_mirror) else $error("enable mirror wrong");
	property p_line_err; id_rd && SOURCES.line_error |=> RDATA[5:0] == ID_LINE_ERROR; endproperty
	a_line_err: assert property (p_line_err) else $error("top source wrong");
	property p_tx_flush; s_fc_en ##0 ACCESS.wdata[2] |=> TX_FIFO_FLUSH; endproperty
	a_tx_flush: assert property (p_tx_flush) else $error("tx flush missing");
	property p_rx_flush; s_fc_en ##0 ACCESS.wdata[1] |=> RX_FIFO_FLUSH; endproperty
	a_rx_flush: assert property (p_rx_flush) else $error("rx flush missing");
	property p_trig_off; !FIFO_ENABLE |=> RX_TRIGGER == TRIG_SINGLE && TX_TRIGGER == TRIG_SINGLE; endproperty
	a_trig_off: assert property (p_trig_off) else $error("trigger not one");
	property p_rx_trig; s_fc_en ##0 ACCESS.wdata[7:6] == 2'b11 |=> ##1 RX_TRIGGER == RX_TRIG_11; endproperty
	a_rx_trig: assert property (p_rx_trig) else $error("rx trigger wrong");
endmodule
bind uicfc_regs uicfc_regs_asserts uicfc_regs_asserts_i (.CLOCK, .RSTN, .ACCESS, .LINE_CONTROL,
	.SOURCES, .RDATA, .BAUD_DIVISOR_HIGH, .FIFO_ENABLE, .RX_TRIGGER, .TX_TRIGGER, .TX_FIFO_FLUSH, .RX_FIFO_FLUSH);

/* File: dv/uicfc_host.sv */
// Host model issuing register reads and writes.
// Assumes the bench clock; one access at a time.
`timescale 1ns/10ps
module uicfc_host
	import uicfc_pkg::*;
(
	input  wire logic              clock,
	output uicfc_pkg::uicfc_access_t access
);
	initial access = '0;
	// Strobe for one edge only; writes never read back
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		access <= '{w, !w, a, d};
		@(posedge clock);
		access <= '0;
	endtask
endmodule

/* File: dv/uicfc_regs_test.sv */
// Self-checking bench for uicfc_regs.
// Assumes the host model and checker; 200 MHz clock.
`timescale 1ns/10ps
`define CHK(a, e) \
	begin \
		comparisons++; \
		if ((a) !== (e)) \
		begin \
			mismatches++; \
			$display("wrong value at %0t: %h not %h", $time, a, e); \
		end \
	end
module uicfc_regs_test;
	import uicfc_pkg::*;
	logic clock = 0, rstn = 0, soft_reset = 0, fifo_enable, tx_fifo_flush, rx_fifo_flush, rdata_valid;
	logic [7:0] line_control = 8'h00, enhanced_feature = 8'h10, rdata, baud_divisor_high, bd, expected, notes[$];
	logic [6:0] rx_trigger, tx_trigger;
	uicfc_sources_t sources = '0;
	uicfc_access_t access;
	int mismatches = 0, comparisons = 0, cycles = 0, seed = 32'h9c89;
	localparam logic [6:0] rxt[4] = '{RX_TRIG_00, RX_TRIG_01, RX_TRIG_10, RX_TRIG_11};
	localparam logic [6:0] txt[4] = '{TX_TRIG_00, TX_TRIG_01, TX_TRIG_10, TX_TRIG_11};
	// Bit k of the sources struct; pulse-only flags hold zero
	localparam logic [5:0] ids[10] = '{ID_FLOW_DROP, 6'h00, 6'h00, 6'h00, ID_PIN_CHANGE, ID_MODEM, ID_TX_READY,
		ID_RX_DATA, ID_RX_TIMEOUT, ID_LINE_ERROR};
	always #2.5 clock = ~clock;
	uicfc_host uicfc_host_i (.clock(clock), .access(access));
	uicfc_regs uicfc_regs_i (.CLOCK(clock), .RSTN(rstn), .SOFT_RESET(soft_reset), .ACCESS(access),
		.LINE_CONTROL(line_control), .ENHANCED_FEATURE(enhanced_feature), .SOURCES(sources), .RDATA(rdata),
		.RDATA_VALID(rdata_valid), .BAUD_DIVISOR_HIGH(baud_divisor_high), .FIFO_ENABLE(fifo_enable),
		.RX_TRIGGER(rx_trigger), .TX_TRIGGER(tx_trigger), .TX_FIFO_FLUSH(tx_fifo_flush),
		.RX_FIFO_FLUSH(rx_fifo_flush));
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		uicfc_host_i.xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		notes.push_back(e);
		uicfc_host_i.xfer(1'b0, a, 8'h00);
	endtask
	task automatic pulse(input int k);
		@(posedge clock);
		sources[k] <= 1'b1;
		@(posedge clock);
		sources[k] <= 1'b0;
	endtask
	task automatic results();
		$display("%0d comparisons, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Read data is checked mid-cycle, clear of the launching edge
	always @(negedge clock)
		if (rdata_valid === 1'b1)
		begin
			expected = notes.pop_front();
			`CHK(rdata, expected)
		end
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			mismatches++;
			results();
		end
	end
	initial
	begin
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		`CHK(baud_divisor_high, 8'h00)
		rd(8'h02, 8'h01);
		bd = 8'($random(seed));
		line_control <= 8'h80;
		wr(8'h01, bd);
		line_control <= 8'hbf;
		wr(8'h01, ~bd);
		line_control <= 8'h00;
		wr(8'h01, 8'($random(seed)));
		soft_reset <= 1'b1;
		@(posedge clock);
		soft_reset <= 1'b0;
		line_control <= 8'h80;
		rd(8'h01, bd);
		`CHK(baud_divisor_high, bd)
		line_control <= 8'h00;
		$display("divisor test done");
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h02, {c[1:0], c[1:0], 4'h1});
			repeat (2) @(negedge clock);
			`CHK(rx_trigger, rxt[c])
			`CHK(tx_trigger, txt[c])
		end
		@(posedge clock);
		enhanced_feature <= 8'h00;
		wr(8'h02, 8'h01);
		repeat (2) @(negedge clock);
		`CHK(tx_trigger, TX_TRIG_11)
		wr(8'h02, 8'h07);
		@(negedge clock);
		`CHK({tx_fifo_flush, rx_fifo_flush}, 2'b11)
		`CHK(fifo_enable, 1'b1)
		@(negedge clock);
		`CHK({tx_fifo_flush, rx_fifo_flush}, 2'b00)
		$display("fifo control test done");
		@(posedge clock);
		for (int k = 0; k < 10; k++)
		begin
			if (k == 0 || k > 3)
			begin
				sources[k] <= 1'b1;
				rd(8'h02, {2'b11, ids[k]});
			end
		end
		sources <= '0;
		pulse(3);
		rd(8'h02, 8'hd0);
		rd(8'h02, 8'hd0);
		pulse(1);
		rd(8'h02, 8'hc1);
		pulse(2);
		rd(8'h02, 8'hd0);
		rd(8'h02, 8'hc1);
		wr(8'h02, 8'h00);
		repeat (2) @(negedge clock);
		`CHK(rx_trigger, TRIG_SINGLE)
		rd(8'h02, 8'h01);
		wr(8'h02, 8'h01);
		@(negedge clock);
		`CHK(fifo_enable, 1'b1)
		@(posedge clock);
		soft_reset <= 1'b1;
		@(posedge clock);
		soft_reset <= 1'b0;
		@(negedge clock);
		`CHK(fifo_enable, 1'b0)
		repeat (3) @(posedge clock);
		`CHK(notes.size(), 0)
		$display("identification test done");
		results();
	end
endmodule
